// ===== hdl/iag_adder.sv
// wrap-around address adder
// assumes operands arrive combinationally from the generator
`timescale 1ns/10ps
module iag_adder #(
  parameter int W = 16
) (
  // operands and result
  iag_calc_if.adder calc
);
  if (W < 1) begin : g_bad_w
    $error("iag_adder width must be positive");
  end

  // sum drops the carry so it wraps within the space
  assign calc.sum = calc.base + calc.offs; // see RQ5
endmodule // iag_adder

// ===== hdl/iag_calc_if.sv
// adder operand and result bundle between generator and adder
// assumes both ends run in the same combinational cone
`timescale 1ns/10ps
interface iag_calc_if #(parameter int W = 16);
  logic [W-1:0] base;
  logic [W-1:0] offs;
  logic [W-1:0] sum;
  modport adder (input base, input offs, output sum);
  modport user (output base, output offs, input sum);
endinterface // iag_calc_if

// ===== hdl/iag_pkg.sv
// constants, types and state layout of the indexed address generator
// assumes a 16-bit core with a 64-Kbyte address space
//
// Summary of operation
// RQ1: opcode, postbyte, then zero to two extensions
// RQ2: signed 5, 9, 16-bit offsets plus base
// RQ3: 5-bit offset lives in postbyte, any base
// RQ4: 9-bit sign in postbyte, low byte follows
// RQ5: 16-bit offset from two bytes, wraps
// RQ6: auto-modify by one to eight, pre or post
// RQ7: auto-modify bases exclude the program counter
// RQ8: stack pointer everywhere, program counter mostly
// RQ9: accumulator A, B or D added to base
// RQ10: accumulator offset leaves base untouched
// RQ11: indirect forms read 16-bit pointer at address
// RQ12: indirect forms accept all four bases
// RQ13: zero flag follows loaded value only
// RQ14: program counter base is next instruction address
package iag_pkg;

  // --------------------------------------------------------------
  // widths and field positions
  // --------------------------------------------------------------
  localparam int ADDR_W = 16;
  localparam int PB_GRP_HI = 7;
  localparam int PB_GRP_LO = 5;
  localparam int PB_AUTO_BIT = 5;
  localparam int PB_POST_BIT = 4;
  localparam int PB_SIGN5_BIT = 4;
  localparam logic [2:0] PB_GRP_EXT = 3'h7;

  // --------------------------------------------------------------
  // base register select codes
  // --------------------------------------------------------------
  localparam logic [1:0] BASE_X = 2'h0;
  localparam logic [1:0] BASE_Y = 2'h1;
  localparam logic [1:0] BASE_SP = 2'h2;
  localparam logic [1:0] BASE_PC = 2'h3;

  // --------------------------------------------------------------
  // low three bits of the extended group
  // --------------------------------------------------------------
  localparam logic [2:0] EXT_OFS9_POS = 3'h0;
  localparam logic [2:0] EXT_OFS9_NEG = 3'h1;
  localparam logic [2:0] EXT_OFS16 = 3'h2;
  localparam logic [2:0] EXT_OFS16_IND = 3'h3;
  localparam logic [2:0] EXT_ACC_A = 3'h4;
  localparam logic [2:0] EXT_ACC_B = 3'h5;
  localparam logic [2:0] EXT_ACC_D = 3'h6;
  localparam logic [2:0] EXT_ACC_D_IND = 3'h7;

  // --------------------------------------------------------------
  // reset values and state
  // --------------------------------------------------------------
  localparam logic [ADDR_W-1:0] ADDR_RST = 16'h0000;

  typedef enum logic [1:0] {
    IAG_IDLE = 2'h0,
    IAG_DONE = 2'h1,
    IAG_PTR = 2'h3
  } iag_state_e;

  typedef struct packed {
    iag_state_e st;
    logic [ADDR_W-1:0] ea;
    logic [ADDR_W-1:0] base_val;
    logic [1:0] base_sel;
    logic base_we;
    logic [1:0] ext_n;
    logic zero;
  } iag_regs_s;

endpackage

// ===== hdl/iag_top.sv
// indexed address generator: decodes postbyte and extension bytes
// assumes the queue presents the postbyte and the next two bytes and
// the core holds its registers stable while a request is taken
`timescale 1ns/10ps
module iag_top
  import iag_pkg::*;
#(
  parameter int TAIL_W = 2
) (
  // clock and reset
  input wire logic CORE_CLK,
  input wire logic RST,
  // instruction queue side
  input wire logic REQ_VALID,
  output logic REQ_READY,
  input wire logic [7:0] POSTBYTE,
  input wire logic [7:0] EXT_BYTE_1,
  input wire logic [7:0] EXT_BYTE_2,
  input wire logic [ADDR_W-1:0] PC_POSTBYTE,
  input wire logic [TAIL_W-1:0] TAIL_BYTES,
  // core registers
  input wire logic [ADDR_W-1:0] INDEX_X,
  input wire logic [ADDR_W-1:0] INDEX_Y,
  input wire logic [ADDR_W-1:0] STACK_POINTER,
  input wire logic [7:0] ACC_A,
  input wire logic [7:0] ACC_B,
  // pointer fetch on the memory bus
  output logic MEM_REQ,
  output logic [ADDR_W-1:0] MEM_ADDR,
  input wire logic MEM_ACK,
  input wire logic [ADDR_W-1:0] MEM_RDATA,
  // result
  output logic EA_VALID,
  output logic [ADDR_W-1:0] EA,
  output logic [1:0] EXT_COUNT,
  output logic BASE_WE,
  output logic [1:0] BASE_SEL,
  output logic [ADDR_W-1:0] BASE_VALUE,
  // loaded operand and zero flag
  input wire logic LOAD_VALID,
  input wire logic [ADDR_W-1:0] LOAD_DATA,
  output logic ZERO_FLAG
);

  // ----------------------------------------------------------------
  // parameter check
  // ----------------------------------------------------------------
  // byte concatenations below assume a two-byte address
  if (ADDR_W != 16) begin : g_bad_addr
    $error("iag_top needs a 16-bit address");
  end
  if (TAIL_W < 1 || TAIL_W > 4) begin : g_bad_tail
    $error("iag_top TAIL_W must be 1 to 4");
  end

  // ----------------------------------------------------------------
  // state and adders
  // ----------------------------------------------------------------
  iag_regs_s r_reg;
  iag_regs_s r_next;
  logic [1:0] rr;
  logic [ADDR_W-1:0] offs;
  logic [ADDR_W-1:0] delta;
  logic [ADDR_W-1:0] base;
  logic [ADDR_W-1:0] pc_base;
  logic [1:0] ext;
  logic ind;
  logic auto_mod;
  logic pre;

  iag_calc_if #(.W(ADDR_W)) ea_if ();
  iag_calc_if #(.W(ADDR_W)) mod_if ();

  iag_adder #(.W(ADDR_W)) u_ea_add (
    .calc(ea_if.adder)
  );

  iag_adder #(.W(ADDR_W)) u_mod_add (
    .calc(mod_if.adder)
  );

  // ----------------------------------------------------------------
  // postbyte decode
  // ----------------------------------------------------------------
  always_comb begin
    rr = POSTBYTE[PB_GRP_HI:PB_GRP_HI-1];
    offs = '0;
    delta = '0;
    ext = 2'h0;
    ind = 1'b0;
    auto_mod = 1'b0;
    pre = 1'b0;
    if (POSTBYTE[PB_GRP_HI:PB_GRP_LO] == PB_GRP_EXT) begin
      rr = POSTBYTE[4:3]; // see RQ8 see RQ12
      case (POSTBYTE[2:0])
        EXT_OFS9_POS, EXT_OFS9_NEG: begin
          offs = {{8{POSTBYTE[0]}}, EXT_BYTE_1}; // see RQ4
          ext = 2'h1;
        end
        EXT_OFS16: begin
          offs = {EXT_BYTE_1, EXT_BYTE_2}; // see RQ5
          ext = 2'h2;
        end
        EXT_OFS16_IND: begin
          offs = {EXT_BYTE_1, EXT_BYTE_2}; // see RQ11
          ext = 2'h2;
          ind = 1'b1;
        end
        // accumulator offsets are zero extended
        EXT_ACC_A: offs = {8'h00, ACC_A}; // see RQ9
        EXT_ACC_B: offs = {8'h00, ACC_B}; // see RQ9
        EXT_ACC_D: offs = {ACC_A, ACC_B}; // see RQ9
        EXT_ACC_D_IND: begin
          offs = {ACC_A, ACC_B}; // see RQ11
          ind = 1'b1;
        end
        default: offs = '0;
      endcase
    end else if (!POSTBYTE[PB_AUTO_BIT]) begin
      // offset inside the postbyte, no extension
      offs = {{11{POSTBYTE[PB_SIGN5_BIT]}}, POSTBYTE[4:0]}; // see RQ3
    end else begin
      // group 111 is taken above, so rr is never the pc here
      auto_mod = 1'b1; // see RQ7
      pre = !POSTBYTE[PB_POST_BIT];
      if (POSTBYTE[3]) begin
        delta = {12'hfff, POSTBYTE[3:0]}; // see RQ6
      end else begin
        delta = {12'h000, POSTBYTE[3:0]} + 16'h0001; // see RQ6
      end
    end
  end

  // ----------------------------------------------------------------
  // base select and adder operands
  // ----------------------------------------------------------------
  always_comb begin
    // pc base points past the whole instruction
    pc_base = PC_POSTBYTE + 16'h0001 + {14'h0000, ext}
      + ADDR_W'(TAIL_BYTES); // see RQ14
    case (rr)
      BASE_X: base = INDEX_X;
      BASE_Y: base = INDEX_Y;
      BASE_SP: base = STACK_POINTER; // see RQ8
      default: base = pc_base;
    endcase
    // post forms address with the old base, pre forms with the new
    ea_if.base = base;
    ea_if.offs = auto_mod ? (pre ? delta : '0) : offs; // see RQ2 see RQ6
    mod_if.base = base;
    mod_if.offs = delta;
  end

  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  always_comb begin
    r_next = r_reg;
    r_next.base_we = 1'b0;
    case (r_reg.st)
      IAG_IDLE: begin
        if (REQ_VALID) begin
          r_next.ea = ea_if.sum;
          r_next.ext_n = ext; // see RQ1
          r_next.base_sel = rr;
          // only auto-modify writes the base back
          r_next.base_val = mod_if.sum; // see RQ10
          r_next.base_we = auto_mod; // see RQ6 see RQ10
          r_next.st = ind ? IAG_PTR : IAG_DONE;
        end
      end
      IAG_PTR: begin
        // memory request stays up until the acknowledge edge
        if (MEM_ACK) begin
          r_next.ea = MEM_RDATA; // see RQ11
          r_next.base_we = r_reg.base_we;
          r_next.st = IAG_DONE;
        end else begin
          r_next.base_we = r_reg.base_we;
        end
      end
      IAG_DONE: r_next.st = IAG_IDLE;
      default: r_next.st = IAG_IDLE;
    endcase

    // ------------------------------------------------------------
    // zero flag
    // ------------------------------------------------------------
    // zero flag sees loads only, never the base update
    if (LOAD_VALID) begin
      r_next.zero = (LOAD_DATA == '0); // see RQ13
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      r_reg <= '{st: IAG_IDLE, ea: ADDR_RST, base_val: ADDR_RST,
                 base_sel: BASE_X, base_we: 1'b0, ext_n: 2'h0,
                 zero: 1'b0};
    end else begin
      r_reg <= r_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign REQ_READY = (r_reg.st == IAG_IDLE);
  assign MEM_REQ = (r_reg.st == IAG_PTR);
  assign MEM_ADDR = r_reg.ea; // see RQ11
  assign EA_VALID = (r_reg.st == IAG_DONE);
  assign EA = r_reg.ea;
  assign EXT_COUNT = r_reg.ext_n;
  // base write pulses only in the done cycle
  assign BASE_WE = r_reg.base_we && (r_reg.st == IAG_DONE);
  assign BASE_SEL = r_reg.base_sel;
  assign BASE_VALUE = r_reg.base_val;
  assign ZERO_FLAG = r_reg.zero;

endmodule // iag_top

// ===== tb/iag_checker.sv
// assertions on the address generator top ports
// assumes it is bound into iag_top
`timescale 1ns/10ps
module iag_checker (
  // clock and reset
  input wire logic CORE_CLK,
  input wire logic RST,
  // request side
  input wire logic REQ_VALID,
  input wire logic REQ_READY,
  input wire logic [7:0] POSTBYTE,
  input wire logic [7:0] EXT_BYTE_1,
  input wire logic [7:0] EXT_BYTE_2,
  input wire logic [15:0] INDEX_X,
  input wire logic [15:0] INDEX_Y,
  input wire logic [15:0] STACK_POINTER,
  // pointer fetch and result
  input wire logic MEM_REQ,
  input wire logic MEM_ACK,
  input wire logic [15:0] MEM_RDATA,
  input wire logic EA_VALID,
  input wire logic [15:0] EA,
  input wire logic [1:0] EXT_COUNT,
  input wire logic BASE_WE,
  input wire logic [1:0] BASE_SEL,
  // load
  input wire logic LOAD_VALID,
  input wire logic [15:0] LOAD_DATA,
  input wire logic ZERO_FLAG
);
  default clocking dc @(posedge CORE_CLK); endclocking
  default disable iff (RST);
  logic take;
  logic ind;
  logic [15:0] exp_short;
  logic [15:0] exp_nine;
  logic [15:0] exp_wide;
  assign take = REQ_VALID && REQ_READY;
  assign exp_short = INDEX_X + {{11{POSTBYTE[4]}}, POSTBYTE[4:0]};
  assign exp_nine = INDEX_Y + {{8{POSTBYTE[0]}}, EXT_BYTE_1};
  assign exp_wide = STACK_POINTER + {EXT_BYTE_1, EXT_BYTE_2};
  assign ind = POSTBYTE[7:5] == 3'h7 && POSTBYTE[1:0] == 2'h3;
  sequence s_done;
    EA_VALID && !REQ_READY;
  endsequence
  sequence s_ptr_back;
    MEM_REQ && MEM_ACK ##1 EA_VALID;
  endsequence
  a_direct_answer: assert property (take && !ind |=> s_done)
    else $error("direct form gave no result");
  a_short_offset: assert property (take && POSTBYTE[7:5] == 3'h0
    |=> EA == $past(exp_short))
    else $error("short offset address wrong");
  a_nine_offset: assert property (take && POSTBYTE[7:1] == 7'h74
    |=> EXT_COUNT == 2'h1 && EA == $past(exp_nine))
    else $error("nine bit offset address wrong");
  a_wide_offset: assert property (take && POSTBYTE == 8'hf2
    |=> EA == $past(exp_wide))
    else $error("wide offset address wrong");
  a_auto_base: assert property (BASE_WE |-> s_done ##0
    BASE_SEL != 2'h3) else $error("base write out of place");
  a_acc_keep: assert property (take && POSTBYTE[7:5] == 3'h7
    && POSTBYTE[2] |=> !BASE_WE) else $error("accumulator form wrote base");
  a_ptr_result: assert property (s_ptr_back |->
    EA == $past(MEM_RDATA) && !BASE_WE) else $error("pointer not used");
  a_ptr_start: assert property (take && ind
    |=> MEM_REQ && !EA_VALID) else $error("indirect form did not fetch");
  a_ptr_done: assert property (MEM_REQ && MEM_ACK |=> s_done)
    else $error("pointer fetch gave no result");
  a_zero_load: assert property (LOAD_VALID |=>
    ZERO_FLAG == ($past(LOAD_DATA) == 16'h0000)) else $error("zero wrong");
endmodule // iag_checker

bind iag_top iag_checker chk_u (.CORE_CLK(CORE_CLK), .RST(RST),
  .REQ_VALID(REQ_VALID), .REQ_READY(REQ_READY), .POSTBYTE(POSTBYTE),
  .EXT_BYTE_1(EXT_BYTE_1), .EXT_BYTE_2(EXT_BYTE_2), .INDEX_X(INDEX_X),
  .INDEX_Y(INDEX_Y), .STACK_POINTER(STACK_POINTER), .MEM_REQ(MEM_REQ),
  .MEM_ACK(MEM_ACK), .MEM_RDATA(MEM_RDATA), .EA_VALID(EA_VALID), .EA(EA),
  .EXT_COUNT(EXT_COUNT), .BASE_WE(BASE_WE), .BASE_SEL(BASE_SEL),
  .LOAD_VALID(LOAD_VALID), .LOAD_DATA(LOAD_DATA), .ZERO_FLAG(ZERO_FLAG));

// ===== tb/iag_mem_model.sv
// memory bus responder returning pointer words
// assumes requests are held until acknowledged
`timescale 1ns/10ps
module iag_mem_model (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // bus
  input wire logic mem_req,
  input wire logic [15:0] mem_addr,
  input wire logic [3:0] lag,
  output logic mem_ack,
  output logic [15:0] mem_rdata
);
  logic [3:0] cnt = 4'h0;
  initial mem_ack = 1'b0;
  initial mem_rdata = 16'hffff;
  always @(negedge clk) begin
    if (mem_ack || rst || !mem_req) begin
      mem_ack <= 1'b0;
      cnt <= 4'h0;
      mem_rdata <= ~mem_rdata;
    end else if (cnt == lag) begin
      mem_ack <= 1'b1;
      mem_rdata <= mem_addr ^ 16'h5a5a;
    end else begin
      cnt <= cnt + 4'h1;
    end
  end
endmodule // iag_mem_model

// ===== tb/iag_top_bench.sv
// self-checking bench for the address generator
// assumes iag_top and the memory responder model
`timescale 1ns/10ps
module iag_top_bench
  import iag_pkg::*;
;
  logic CORE_CLK = 1'b0, RST = 1'b1, REQ_VALID = 1'b0, LOAD_VALID = 1'b0;
  logic REQ_READY, MEM_REQ, MEM_ACK, EA_VALID, BASE_WE, ZERO_FLAG;
  logic [7:0] POSTBYTE = 8'h00, EXT_BYTE_1 = 8'h00, EXT_BYTE_2 = 8'h00;
  logic [7:0] ACC_A = 8'h81, ACC_B = 8'h05;
  logic [15:0] INDEX_X = 16'h1000, INDEX_Y = 16'h2000;
  logic [15:0] STACK_POINTER = 16'h9000, PC_POSTBYTE = 16'h4000;
  logic [15:0] LOAD_DATA = 16'h0000, MEM_ADDR, MEM_RDATA, EA, BASE_VALUE;
  logic [1:0] TAIL_BYTES = 2'h1, EXT_COUNT, BASE_SEL;
  logic [3:0] lag = 4'h0;
  int bad_count = 0, checked = 0;
  always #10 CORE_CLK = ~CORE_CLK;
  iag_top dut_u (.CORE_CLK(CORE_CLK), .RST(RST), .REQ_VALID(REQ_VALID),
    .REQ_READY(REQ_READY), .POSTBYTE(POSTBYTE), .EXT_BYTE_1(EXT_BYTE_1),
    .EXT_BYTE_2(EXT_BYTE_2), .PC_POSTBYTE(PC_POSTBYTE),
    .TAIL_BYTES(TAIL_BYTES), .INDEX_X(INDEX_X), .INDEX_Y(INDEX_Y),
    .STACK_POINTER(STACK_POINTER), .ACC_A(ACC_A), .ACC_B(ACC_B),
    .MEM_REQ(MEM_REQ), .MEM_ADDR(MEM_ADDR), .MEM_ACK(MEM_ACK),
    .MEM_RDATA(MEM_RDATA), .EA_VALID(EA_VALID), .EA(EA),
    .EXT_COUNT(EXT_COUNT), .BASE_WE(BASE_WE), .BASE_SEL(BASE_SEL),
    .BASE_VALUE(BASE_VALUE), .LOAD_VALID(LOAD_VALID),
    .LOAD_DATA(LOAD_DATA), .ZERO_FLAG(ZERO_FLAG));
  iag_mem_model mem_u (.clk(CORE_CLK), .rst(RST), .mem_req(MEM_REQ),
    .mem_addr(MEM_ADDR), .lag(lag), .mem_ack(MEM_ACK), .mem_rdata(MEM_RDATA));
  task chk(input string what, input logic [15:0] exp, got);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task run(input logic [7:0] pb, e1, e2, input logic [15:0] ea, bv,
    input logic we);
    int n;
    n = 0;
    @(negedge CORE_CLK);
    POSTBYTE = pb;
    EXT_BYTE_1 = e1;
    EXT_BYTE_2 = e2;
    REQ_VALID = 1'b1;
    @(negedge CORE_CLK);
    REQ_VALID = 1'b0;
    while (EA_VALID !== 1'b1 && n < 20) begin
      @(negedge CORE_CLK);
      n++;
    end
    if (n >= 20) begin
      bad_count++;
      $display("ERROR ea_valid expected 1 seen timeout");
    end
    chk("ea", ea, EA);
    chk("base_we", {15'h0, we}, {15'h0, BASE_WE});
    if (we) chk("base_value", bv, BASE_VALUE);
  endtask
  task t_const;
    run(8'h10, 8'h00, 8'h00, 16'h0ff0, 16'h0, 1'b0);
    run(8'h9f, 8'h00, 8'h00, 16'h8fff, 16'h0, 1'b0);
    run(8'hcf, 8'h00, 8'h00, 16'h4011, 16'h0, 1'b0);
    run(8'he9, 8'h10, 8'h00, 16'h1f10, 16'h0, 1'b0);
    chk("ext_count", 16'h1, {14'h0, EXT_COUNT});
    run(8'hf2, 8'h80, 8'h01, 16'h1001, 16'h0, 1'b0);
    chk("ext_count", 16'h2, {14'h0, EXT_COUNT});
    $display("test const done");
  endtask
  task t_auto;
    run(8'h71, 8'h00, 8'h00, 16'h2000, 16'h2002, 1'b1);
    chk("base_sel", 16'h1, {14'h0, BASE_SEL});
    run(8'ha8, 8'h00, 8'h00, 16'h8ff8, 16'h8ff8, 1'b1);
    chk("base_sel", 16'h2, {14'h0, BASE_SEL});
    $display("test auto done");
  endtask
  task t_acc;
    run(8'he5, 8'h00, 8'h00, 16'h1005, 16'h0, 1'b0);
    run(8'he4, 8'h00, 8'h00, 16'h1081, 16'h0, 1'b0);
    run(8'hee, 8'h00, 8'h00, 16'ha105, 16'h0, 1'b0);
    $display("test acc done");
  endtask
  task t_ind;
    lag = 4'h3;
    run(8'hfb, 8'h01, 8'h00, 16'h1b5e, 16'h0, 1'b0);
    lag = 4'h0;
    run(8'he7, 8'h00, 8'h00, 16'hcb5f, 16'h0, 1'b0);
    $display("test ind done");
  endtask
  task t_reset;
    @(negedge CORE_CLK);
    RST = 1'b1;
    repeat (2) @(negedge CORE_CLK);
    chk("ready", 16'h1, {15'h0, REQ_READY});
    chk("ea", 16'h0, EA);
    chk("ext_count", 16'h0, {14'h0, EXT_COUNT});
    chk("base_value", 16'h0, BASE_VALUE);
    RST = 1'b0;
    $display("test reset done");
  endtask
  task t_zero;
    @(negedge CORE_CLK);
    LOAD_VALID = 1'b1;
    @(negedge CORE_CLK);
    LOAD_VALID = 1'b0;
    chk("zero", 16'h1, {15'h0, ZERO_FLAG});
    run(8'h71, 8'h00, 8'h00, 16'h2000, 16'h2002, 1'b1);
    chk("zero", 16'h1, {15'h0, ZERO_FLAG});
    LOAD_DATA = 16'h0100;
    LOAD_VALID = 1'b1;
    @(negedge CORE_CLK);
    LOAD_VALID = 1'b0;
    chk("zero", 16'h0, {15'h0, ZERO_FLAG});
    $display("test zero done");
  endtask
  task test_done;
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    repeat (16) @(negedge CORE_CLK);
    RST = 1'b0;
    t_const;
    t_auto;
    t_acc;
    t_ind;
    t_reset;
    t_zero;
    test_done;
  end
  initial begin
    repeat (2000) @(posedge CORE_CLK);
    bad_count++;
    test_done;
  end
endmodule // iag_top_bench
